// ### tb_x25_capture_filter.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Bench
// ********
module tb_x25_capture_filter;
    import xcf_pkg::*;
    logic            sys_clk;
    logic            resetn;
    xcf_axi_req_type axi_req;
    xcf_axi_rsp_type axi_rsp;
    logic            in_valid;
    logic            in_ready;
    xcf_rec_type     in_rec;
    logic            out_valid;
    logic            out_ready;
    xcf_rec_type     out_rec;
    logic            irq;
    logic            err;
    logic            stall;
    int              n_mismatch = 0;
    int              samples_checked = 0;
    int              cyc = 0;
    logic [31:0]     rv;
    logic [1:0]      re;
    logic [1:0]      be;

    xcf_capture_filter dut (
        .sys_clk(sys_clk), .resetn(resetn), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .in_valid(in_valid), .in_ready(in_ready),
        .in_rec(in_rec), .out_valid(out_valid), .out_ready(out_ready),
        .out_rec(out_rec), .irq(irq), .channel_table_full_error(err));
    xcf_store_model store (.stall(stall), .out_ready(out_ready));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Run is under two hundred cycles; far above means a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk32(string w, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic chk1(string w, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %b got %b", w, e, g);
        end
    endtask
    task automatic chkrec(string w, xcf_rec_type e, xcf_rec_type g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do @(posedge sys_clk); while (!(axi_rsp.awready && axi_rsp.wready));
        axi_req.awvalid <= 1'b0;
        axi_req.wvalid <= 1'b0;
        do @(posedge sys_clk); while (!axi_rsp.bvalid);
        be = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] e);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do @(posedge sys_clk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        do @(posedge sys_clk); while (!axi_rsp.rvalid);
        d = axi_rsp.rdata;
        e = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
    task automatic rchk(string w, logic [7:0] a, logic [31:0] e);
        rd(a, rv, re);
        chk32(w, e, rv);
    endtask
    task automatic tvn(int e);
        rd(OFF_TBLV, rv, re);
        chk32("table", 32'(e), 32'($countones(rv[3:0])));
    endtask
    task automatic send(xcf_rec_type r, logic e);
        in_rec <= r;
        in_valid <= 1'b1;
        do @(posedge sys_clk); while (!in_ready);
        in_valid <= 1'b0;
        #1 chk1("out_valid", e, out_valid);
        if (e) chkrec("out_rec", r, out_rec);
        @(posedge sys_clk);
    endtask
    function automatic xcf_rec_type pk(logic [7:0] c, logic [11:0] ch,
                                       logic [7:0] pt, logic ext);
        xcf_rec_type r;
        r = '0;
        r.hdr[0] = c;
        r.hdr[1] = {4'h1, ch[11:8]};
        r.hdr[2] = ch[7:0];
        r.hdr[3] = pt;
        // Extended control adds a second control octet
        if (ext) begin
            r.hdr[4:2] = r.hdr[3:1];
            r.hdr[1] = 8'h00;
        end
        return r;
    endfunction
    function automatic xcf_rec_type kd(logic [1:0] k);
        kd = pk(8'h00, 12'h001, 8'h00, 1'b0);
        kd.kind = k;
    endfunction
    function automatic xcf_rec_type cl(logic [11:0] ch, logic [4:0] n,
                                       logic bad);
        cl = pk(8'h00, ch, PT_CALL, 1'b0);
        cl.cd_len = n;
        // Digits past the length stay zero to catch a full compare
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                cl.cd_dig[i] = 4'(i + 1);
            end
        end
        if (bad) begin
            cl.cd_dig[1] = 4'h9;
        end
    endfunction

    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        rchk("ctrl", OFF_CTRL, CTRL_RST);
        rchk("tblv", OFF_TBLV, 32'h0);
        rd(8'h40, rv, re);
        chk32("rresp", {30'h0, RESP_ERR}, {30'h0, re});
        wr(8'h40, 32'h0);
        chk32("bresp", {30'h0, RESP_ERR}, {30'h0, be});
        stall <= 1'b1;
        send(kd(KIND_TIME), 1'b1);
        #1 chk1("hold", 1'b1, out_valid);
        chk1("in_ready", 1'b0, in_ready);
        @(posedge sys_clk);
        stall <= 1'b0;
    endtask
    task automatic t_timing();
        wr(OFF_CTRL, 32'h101);
        send(kd(KIND_TIME), 1'b0);
        send(kd(KIND_LEAD), 1'b0);
        send(kd(KIND_FRM), 1'b1);
        wr(OFF_CTRL, 32'h201);
        send(kd(KIND_LEAD), 1'b0);
        wr(OFF_CTRL, 32'h001);
        send(kd(KIND_TIME), 1'b1);
    endtask
    task automatic t_sup();
        logic [7:0] sc [3] = '{8'h01, 8'h05, 8'h09};
        wr(OFF_CTRL, 32'h102);
        foreach (sc[i]) send(pk(sc[i], 12'h001, 8'h00, 1'b0), 1'b0);
        send(pk(8'h00, 12'h001, 8'h00, 1'b0), 1'b1);
        send(pk(8'h03, 12'h001, 8'h00, 1'b0), 1'b1);
    endtask
    task automatic t_chan();
        wr(OFF_CVAL, 32'h5A3);
        wr(OFF_CCARE, 32'hF0F);
        wr(OFF_CTRL, 32'h104);
        send(pk(8'h00, 12'h5B3, 8'h00, 1'b0), 1'b1);
        send(pk(8'h00, 12'h4A3, 8'h00, 1'b0), 1'b0);
        send(pk(8'h00, 12'h000, 8'h00, 1'b0), 1'b1);
        wr(OFF_CTRL, 32'h114);
        send(pk(8'h00, 12'h5A3, 8'h00, 1'b1), 1'b1);
        send(pk(8'h00, 12'h5A2, 8'h00, 1'b1), 1'b0);
        wr(OFF_CCARE, 32'h0);
        send(pk(8'h00, 12'h5A2, 8'h00, 1'b1), 1'b1);
    endtask
    task automatic t_call();
        wr(OFF_CD0, 32'h87654321);
        wr(OFF_CD1, 32'hFFFFFFFF);
        wr(OFF_CD2, 32'hF);
        wr(OFF_ALEN, 32'h20);
        wr(OFF_CTRL, 32'h12C);
        send(cl(12'h101, 5'h11, 1'b1), 1'b0);
        send(cl(12'h101, 5'h11, 1'b0), 1'b1);
        send(cl(12'h102, 5'h03, 1'b0), 1'b1);
        tvn(2);
        send(pk(8'h00, 12'h101, 8'h00, 1'b0), 1'b1);
        send(pk(8'h00, 12'h103, 8'h00, 1'b0), 1'b0);
        send(pk(8'h00, 12'h101, PT_CLRC, 1'b0), 1'b1);
        tvn(1);
        send(pk(8'h00, 12'h101, 8'h00, 1'b0), 1'b0);
        for (int i = 3; i < 6; i++) begin
            send(cl(12'h100 + 12'(i), 5'h11, 1'b0), 1'b1);
        end
        chk1("full", 1'b0, err);
        send(cl(12'h106, 5'h11, 1'b0), 1'b1);
        tvn(4);
        chk1("full", 1'b1, err);
        chk1("irq", 1'b0, irq);
        wr(OFF_MASK, 32'h1);
        chk1("irq", 1'b1, irq);
        send(pk(8'h00, 12'h102, 8'h00, 1'b0), 1'b1);
        rchk("sts", OFF_STS, 32'h7);
        chk1("full", 1'b0, err);
        chk1("irq", 1'b0, irq);
        send(pk(8'h00, 12'h000, PT_RSTC, 1'b0), 1'b1);
        tvn(0);
        send(pk(8'h00, 12'h102, 8'h00, 1'b0), 1'b0);
    endtask
    task automatic t_calling();
        xcf_rec_type r;
        r = cl(12'h201, 5'h11, 1'b1);
        r.cg_dig = r.cd_dig;
        r.cg_len = 5'h11;
        wr(OFF_CG0, 32'h87654321);
        wr(OFF_ALEN, 32'h300);
        wr(OFF_CTRL, 32'h14C);
        send(r, 1'b0);
        r.cg_dig[1] = 4'h2;
        send(r, 1'b1);
        tvn(1);
    endtask

    initial begin
        axi_req = '0;
        in_valid = 1'b0;
        in_rec = '0;
        stall = 1'b0;
        resetn = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_timing();
        t_sup();
        t_chan();
        t_call();
        t_calling();
        final_report();
    end
endmodule
`default_nettype wire

// ### xcf_capture_filter.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Timing-and-lead filter on: drop every timestamp and lead status record.
// - Supervisory filter on: drop RR, RNR, REJ; keep information and unnumbered.
// - Channel filter: 12-bit pattern, each bit match 0, match 1 or ignore.
// - Channel is the 12 bits after the format identifier: group then channel.
// - Call filter on: packet needs channel match and either a table hit or an address-matched call setup.
// - All-ignore channel pattern passes everything; the call filter alone decides (address match or table hit).
// - Call filter on: compare addresses of call request and incoming call.
// - Matching call setup records its channel; that channel is then collected.
// - Clear confirmation from either side removes its channel from the table.
// - The channel table holds at most four channels.
// - Qualifying setup into a full table raises the error; traffic continues.
// - Address length set to ignore means a 17-digit pattern.
// - Pattern digits beyond the packet's own address length are ignored.
// - Packets on channel 0 are always collected.
// - Restart confirmation from either side empties the channel table.
// - Filter acts only for X.25 protocols; extended control picks modulo 128.
// - Passive monitor; store only records meeting all enabled conditions, plus every packet on channel 0.
module xcf_capture_filter (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire xcf_pkg::xcf_axi_req_type axi_req,
    output var  xcf_pkg::xcf_axi_rsp_type axi_rsp,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire xcf_pkg::xcf_rec_type     in_rec,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output var  xcf_pkg::xcf_rec_type     out_rec,
    output logic                          irq,
    output logic                          channel_table_full_error
);
    import xcf_pkg::*;

    xcf_state_type      s;
    xcf_state_type      n;
    logic               act;
    logic               ext;
    logic               trk;
    logic [7:0]         pk0;
    logic [7:0]         pk1;
    logic [7:0]         ptype;
    logic [11:0]        chan;
    logic               is_time;
    logic               is_i;
    logic               is_s;
    logic               chan_ok;
    logic [4:0]         cd_eff;
    logic [4:0]         cg_eff;
    logic [67:0]        cd_pat;
    logic [67:0]        cg_pat;
    logic [DIGITS-1:0]  cd_hit;
    logic [DIGITS-1:0]  cg_hit;
    logic               addr_ok;
    logic               qual;
    logic [3:0]         thit;
    logic [3:0]         free_oh;
    logic [3:0]         add_oh;
    logic [3:0]         del_oh;
    logic [3:0][11:0]   tch_new;
    logic               hit;
    logic               full;
    logic               pass;
    logic               acc;
    logic               aw_take;
    logic               ar_take;
    logic [7:0]         wa;
    logic [7:0]         ra;
    logic [2:0]         sts_set;

    // ****************************************
    // Record decode
    // ****************************************
    assign act = (s.ctrl[CTL_PRO +: 2] == PRO_X25) ||
                 (s.ctrl[CTL_PRO +: 2] == PRO_X21);
    assign ext = s.ctrl[CTL_EXT];
    // Packet header starts after one or two control octets
    assign pk0   = ext ? in_rec.hdr[2] : in_rec.hdr[1];
    assign pk1   = ext ? in_rec.hdr[3] : in_rec.hdr[2];
    assign ptype = ext ? in_rec.hdr[4] : in_rec.hdr[3];
    assign chan  = {pk0[3:0], pk1};
    assign is_time = (in_rec.kind == KIND_TIME) ||
                     (in_rec.kind == KIND_LEAD);
    assign is_i  = (in_rec.kind == KIND_FRM) && !in_rec.hdr[0][0];
    assign is_s  = (in_rec.kind == KIND_FRM) &&
                   (in_rec.hdr[0][1:0] == SUP_CODE);

    // Care bits clear everywhere pass any channel
    assign chan_ok = !s.ctrl[CTL_L3] ||
                     (((chan ^ s.cval[11:0]) & s.ccare[11:0]) == 12'h000);

    // ****************************************
    // Address match
    // ****************************************
    assign cd_eff = s.alen[LEN_CDI] ? MAX_LEN : s.alen[LEN_CD +: 5];
    assign cg_eff = s.alen[LEN_CGI] ? MAX_LEN : s.alen[LEN_CG +: 5];
    assign cd_pat = {s.cdp[2][3:0], s.cdp[1], s.cdp[0]};
    assign cg_pat = {s.cgp[2][3:0], s.cgp[1], s.cgp[0]};

    for (genvar i = 0; i < DIGITS; i++) begin : g_dig
        localparam logic [4:0] POS = 5'(i);
        assign cd_hit[i] = (POS >= cd_eff) || (POS >= in_rec.cd_len) ||
                           (cd_pat[4*i +: 4] == DIG_IGN) ||
                           (cd_pat[4*i +: 4] == in_rec.cd_dig[i]);
        assign cg_hit[i] = (POS >= cg_eff) || (POS >= in_rec.cg_len) ||
                           (cg_pat[4*i +: 4] == DIG_IGN) ||
                           (cg_pat[4*i +: 4] == in_rec.cg_dig[i]);
    end

    assign addr_ok = (!s.ctrl[CTL_CDEN] || (&cd_hit)) &&
                     (!s.ctrl[CTL_CGEN] || (&cg_hit));
    assign trk  = act && s.ctrl[CTL_CALL];
    assign qual = trk && is_i && (ptype == PT_CALL) && addr_ok;

    // ****************************************
    // Channel table
    // ****************************************
    for (genvar k = 0; k < TBL_N; k++) begin : g_tbl
        localparam logic [3:0] LOW = 4'((1 << k) - 1);
        assign thit[k]    = s.tv[k] && (s.tch[k] == chan);
        assign free_oh[k] = !s.tv[k] && ((s.tv & LOW) == LOW);
        assign tch_new[k] = add_oh[k] ? chan : s.tch[k];
    end

    assign hit  = |thit;
    assign full = &s.tv;
    assign acc  = in_valid && in_ready;
    // A table full of four records no fifth call; the call still passes
    assign add_oh = (acc && qual && !hit) ? free_oh : 4'h0;
    assign del_oh = (acc && act && is_i && ptype == PT_CLRC) ?
                    thit : 4'h0;

    // ****************************************
    // Pass decision
    // ****************************************
    always_comb begin
        if (!act) begin
            pass = 1'b1;
        end else if (is_time) begin
            pass = !s.ctrl[CTL_TL];
        end else if (is_s) begin
            pass = !s.ctrl[CTL_SUP];
        end else if (!is_i) begin
            pass = 1'b1;
        end else if (chan == 12'h000) begin
            pass = 1'b1;
        end else begin
            pass = chan_ok &&
                   (!s.ctrl[CTL_CALL] || hit || qual);
        end
    end

    // ****************************************
    // Bus slave
    // ****************************************
    assign aw_take = (s.wst == BUS_IDLE) && axi_req.awvalid &&
                     axi_req.wvalid;
    assign ar_take = (s.rst == BUS_IDLE) && axi_req.arvalid;
    assign wa = {axi_req.awaddr[7:2], 2'h0};
    assign ra = {axi_req.araddr[7:2], 2'h0};

    always_comb begin
        axi_rsp.awready = aw_take;
        axi_rsp.wready  = aw_take;
        axi_rsp.bvalid  = (s.wst == BUS_RESP);
        axi_rsp.bresp   = s.bresp;
        axi_rsp.arready = ar_take;
        axi_rsp.rvalid  = (s.rst == BUS_RESP);
        axi_rsp.rdata   = s.rdata;
        axi_rsp.rresp   = s.rresp;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = s;
        sts_set = 3'h0;
        if (aw_take) begin
            n.wst   = BUS_RESP;
            n.bresp = RESP_OK;
            case (wa)
                OFF_CTRL: begin
                    n.ctrl = wmerge(s.ctrl, axi_req.wdata,
                                    axi_req.wstrb, CTRL_WM);
                end
                OFF_CVAL: begin
                    n.cval = wmerge(s.cval, axi_req.wdata,
                                    axi_req.wstrb, CVAL_WM);
                end
                OFF_CCARE: begin
                    n.ccare = wmerge(s.ccare, axi_req.wdata,
                                     axi_req.wstrb, CVAL_WM);
                end
                OFF_ALEN: begin
                    n.alen = wmerge(s.alen, axi_req.wdata,
                                    axi_req.wstrb, ALEN_WM);
                end
                OFF_CD0: begin
                    n.cdp[0] = wmerge(s.cdp[0], axi_req.wdata,
                                      axi_req.wstrb, PAT_WM);
                end
                OFF_CD1: begin
                    n.cdp[1] = wmerge(s.cdp[1], axi_req.wdata,
                                      axi_req.wstrb, PAT_WM);
                end
                OFF_CD2: begin
                    n.cdp[2] = wmerge(s.cdp[2], axi_req.wdata,
                                      axi_req.wstrb, PAT2_WM);
                end
                OFF_CG0: begin
                    n.cgp[0] = wmerge(s.cgp[0], axi_req.wdata,
                                      axi_req.wstrb, PAT_WM);
                end
                OFF_CG1: begin
                    n.cgp[1] = wmerge(s.cgp[1], axi_req.wdata,
                                      axi_req.wstrb, PAT_WM);
                end
                OFF_CG2: begin
                    n.cgp[2] = wmerge(s.cgp[2], axi_req.wdata,
                                      axi_req.wstrb, PAT2_WM);
                end
                OFF_MASK: begin
                    n.mask = 3'(wmerge({29'h0, s.mask}, axi_req.wdata,
                                       axi_req.wstrb, STS_WM));
                end
                OFF_STS, OFF_TBLV: begin
                    n.bresp = RESP_OK;
                end
                default: begin
                    n.bresp = RESP_ERR;
                end
            endcase
        end else if ((s.wst == BUS_RESP) && axi_req.bready) begin
            n.wst = BUS_IDLE;
        end

        if (ar_take) begin
            n.rst   = BUS_RESP;
            n.rresp = RESP_OK;
            case (ra)
                OFF_CTRL:  n.rdata = s.ctrl;
                OFF_CVAL:  n.rdata = s.cval;
                OFF_CCARE: n.rdata = s.ccare;
                OFF_ALEN:  n.rdata = s.alen;
                OFF_CD0:   n.rdata = s.cdp[0];
                OFF_CD1:   n.rdata = s.cdp[1];
                OFF_CD2:   n.rdata = s.cdp[2];
                OFF_CG0:   n.rdata = s.cgp[0];
                OFF_CG1:   n.rdata = s.cgp[1];
                OFF_CG2:   n.rdata = s.cgp[2];
                OFF_STS:   n.rdata = {29'h0, s.sts};
                OFF_MASK:  n.rdata = {29'h0, s.mask};
                OFF_TBLV:  n.rdata = {28'h0, s.tv};
                default: begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = RESP_ERR;
                end
            endcase
        end else if ((s.rst == BUS_RESP) && axi_req.rready) begin
            n.rst = BUS_IDLE;
        end

        // Table follows the line even for dropped packets
        if (acc && act && is_i && ptype == PT_RSTC) begin
            n.tv = 4'h0;
            sts_set[STS_DEL] = 1'b1;
        end else begin
            n.tv = (s.tv & ~del_oh) | add_oh;
            sts_set[STS_DEL] = |del_oh;
        end
        n.tch = tch_new;
        sts_set[STS_ADD]  = |add_oh;
        sts_set[STS_FULL] = acc && qual && !hit && full;

        // Read clears, but an event in the same cycle still lands
        n.sts = ((ar_take && ra == OFF_STS) ? 3'h0 : s.sts) | sts_set;

        if (acc) begin
            n.ov   = pass;
            n.orec = in_rec;
        end else if (out_ready) begin
            n.ov = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s      <= '0;
            s.wst  <= BUS_IDLE;
            s.rst  <= BUS_IDLE;
            s.ctrl <= CTRL_RST;
        end else begin
            s <= n;
        end
    end

    // Capture store stalls the monitor; one record is held in the output register
    assign in_ready  = !s.ov || out_ready;
    assign out_valid = s.ov;
    assign out_rec   = s.orec;
    assign irq       = |(s.sts & s.mask);
    assign channel_table_full_error = s.sts[STS_FULL];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    time_drop_a: assert property (acc && act && s.ctrl[CTL_TL] &&
        is_time |=> !out_valid) else $error("timing record stored");
    sup_drop_a: assert property (acc && act && s.ctrl[CTL_SUP] &&
        is_s |=> !out_valid) else $error("supervisory frame stored");
    chan_miss_a: assert property (acc && act && is_i &&
        s.ctrl[CTL_L3] && chan != 12'h000 &&
        ((chan ^ s.cval[11:0]) & s.ccare[11:0]) != 12'h000
        |=> !out_valid) else $error("channel mismatch stored");
    chan_zero_a: assert property (acc && act && is_i &&
        chan == 12'h000 |=> out_valid) else $error("channel 0 lost");
    tbl_add_a: assert property (acc && qual && !hit && !full
        |=> $countones(s.tv) == $countones($past(s.tv)) + 1)
        else $error("call not recorded");
    tbl_full_a: assert property (acc && qual && !hit && full
        |=> channel_table_full_error && s.tv == $past(s.tv))
        else $error("full table mishandled");
    tbl_clear_a: assert property (acc && act && is_i &&
        ptype == PT_CLRC && hit
        |=> $countones(s.tv) < $countones($past(s.tv)))
        else $error("clear not applied");
    restart_a: assert property (acc && act && is_i &&
        ptype == PT_RSTC |=> s.tv == 4'h0)
        else $error("restart left entries");
    bypass_a: assert property (acc && !act
        |=> out_valid && out_rec == $past(in_rec))
        else $error("inactive filter dropped record");
    all_care_a: assert property (acc && act && is_i &&
        s.ctrl[CTL_L3] && !s.ctrl[CTL_CALL] && s.ccare[11:0] == 12'h000
        |=> out_valid) else $error("channel ignore dropped");
    addr_miss_a: assert property (acc && trk && is_i &&
        ptype == PT_CALL && !addr_ok && !hit && chan != 12'h000
        |=> !out_valid) else $error("bad call stored");
    // Ignore length means all digits
    len_ign_a: assert property (s.alen[LEN_CDI]
        |-> cd_eff == 5'(DIGITS))
        else $error("length short");
    rec_copy_a: assert property (acc
        |=> out_rec == $past(in_rec))
        else $error("record altered");
    // Stall keeps the record
    stall_hold_a: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_rec))
        else $error("stall lost record");
    full_sticky_a: assert property (channel_table_full_error &&
        !(ar_take && ra == OFF_STS) |=> channel_table_full_error)
        else $error("error cleared early");

    // ****************************************
    // Cover points
    // ****************************************
    call_cov: cover property (acc && qual && !hit && !full);
    del_cov:  cover property (acc && act && is_i && ptype == PT_CLRC && hit);
    over_cov: cover property (acc && qual && !hit && full);
    rst_cov:  cover property (acc && act && is_i && ptype == PT_RSTC);
    hit_cov:  cover property (acc && s.ctrl[CTL_CALL] && hit && pass);
endmodule
`default_nettype wire

// ### xcf_pkg.sv
`default_nettype none
package xcf_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_CVAL  = 8'h04;
    localparam logic [7:0] OFF_CCARE = 8'h08;
    localparam logic [7:0] OFF_ALEN  = 8'h0C;
    localparam logic [7:0] OFF_CD0   = 8'h10;
    localparam logic [7:0] OFF_CD1   = 8'h14;
    localparam logic [7:0] OFF_CD2   = 8'h18;
    localparam logic [7:0] OFF_CG0   = 8'h1C;
    localparam logic [7:0] OFF_CG1   = 8'h20;
    localparam logic [7:0] OFF_CG2   = 8'h24;
    localparam logic [7:0] OFF_STS   = 8'h28;
    localparam logic [7:0] OFF_MASK  = 8'h2C;
    localparam logic [7:0] OFF_TBLV  = 8'h30;

    localparam int CTL_TL   = 0;
    localparam int CTL_SUP  = 1;
    localparam int CTL_L3   = 2;
    localparam int CTL_CALL = 3;
    localparam int CTL_EXT  = 4;
    localparam int CTL_CDEN = 5;
    localparam int CTL_CGEN = 6;
    localparam int CTL_PRO  = 8;
    localparam int LEN_CD   = 0;
    localparam int LEN_CDI  = 5;
    localparam int LEN_CG   = 8;
    localparam int LEN_CGI  = 13;
    localparam int STS_FULL = 0;
    localparam int STS_ADD  = 1;
    localparam int STS_DEL  = 2;

    localparam logic [31:0] CTRL_RST = 32'h0000_0100;
    localparam logic [31:0] CTRL_WM  = 32'h0000_037F;
    localparam logic [31:0] CVAL_WM  = 32'h0000_0FFF;
    localparam logic [31:0] ALEN_WM  = 32'h0000_3F3F;
    localparam logic [31:0] PAT_WM   = 32'hFFFF_FFFF;
    localparam logic [31:0] PAT2_WM  = 32'h0000_000F;
    localparam logic [31:0] STS_WM   = 32'h0000_0007;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    // ****************************************
    // Line codes
    // ****************************************
    localparam logic [1:0] PRO_X25   = 2'h1;
    localparam logic [1:0] PRO_X21   = 2'h2;
    localparam logic [1:0] KIND_FRM  = 2'h0;
    localparam logic [1:0] KIND_TIME = 2'h1;
    localparam logic [1:0] KIND_LEAD = 2'h2;
    localparam logic [1:0] SUP_CODE  = 2'h1;
    localparam logic [7:0] PT_CALL   = 8'h0B;
    localparam logic [7:0] PT_CLRC   = 8'h17;
    localparam logic [7:0] PT_RSTC   = 8'hFF;
    localparam int         DIGITS    = 17;
    localparam logic [4:0] MAX_LEN   = 5'h11;
    localparam logic [3:0] DIG_IGN   = 4'hF;
    localparam int         TBL_N     = 4;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } xcf_bus_type;

    typedef struct packed {
        logic [1:0]        kind;
        logic [4:0][7:0]   hdr;
        logic [4:0]        cd_len;
        logic [4:0]        cg_len;
        logic [16:0][3:0]  cd_dig;
        logic [16:0][3:0]  cg_dig;
    } xcf_rec_type;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } xcf_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } xcf_axi_rsp_type;

    typedef struct packed {
        xcf_bus_type            wst;
        xcf_bus_type            rst;
        logic [1:0]             bresp;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        logic [31:0]            ctrl;
        logic [31:0]            cval;
        logic [31:0]            ccare;
        logic [31:0]            alen;
        logic [2:0][31:0]       cdp;
        logic [2:0][31:0]       cgp;
        logic [2:0]             sts;
        logic [2:0]             mask;
        logic [3:0]             tv;
        logic [3:0][11:0]       tch;
        logic                   ov;
        xcf_rec_type            orec;
    } xcf_state_type;

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st,
                                           input logic [31:0] wm);
        logic [31:0] bm;
        bm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return ((old & ~bm) | (wd & bm)) & wm;
    endfunction
endpackage
`default_nettype wire

// ### xcf_store_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Capture store
// ********
module xcf_store_model (
    input  wire logic stall,
    output logic      out_ready
);
    // Stall lets the bench hold a stored record in place
    assign out_ready = !stall;
endmodule
`default_nettype wire
